//--- rtl/serial_frame_device.sv
// Operation
// - Host loads identical config, output control low byte zero
// - Chain uses lane 0, external clock only
// - Capture shifts input pin into shifter LSB
// - Host gives exactly 32 times N edges
// - Long chained frames align each device word
// - Exactly three states: reset, acquisition, conversion
// - Host holds reset pin low minimum width
// - Kind 1: application reset, defaults, outputs off
// - Kind 0: power-on reset, then settling delay
// - Leave reset with select, clock low; ready rises
// - Reset fall to reset; select rise to conversion
// - Conversion ignores select until finished
// - Select fall: ready low, clear, load, no-op
// - Capture counts and shifts; launch drives MSB
// - Select rise: outputs off, hand command, ready low
// - Host waits ready rise or maximum conversion
// - Exactly 32 edges is optimal, command valid
// - Fewer than 32 edges is short, no-op
// - Longer frame uses last 32 bits shifted
// - Writes come only from external serial clock
// - Commands touch one byte or half word
// - Half-word commands force address LSB zero
// - Commands 32 bits, act at select rise
module serial_frame_device
  import serial_frame_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES,
  parameter int APP_LEN = RST_APP_CYCLES,
  parameter int POR_LEN = RST_POR_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  serial_link_if.device link,
  input wire logic [WORD_BITS-1:0] output_word,
  input wire logic reset_kind_select,
  output cmd_op_type cmd_op,
  output logic [8:0] cmd_addr,
  output logic [15:0] cmd_data,
  output logic [1:0] cmd_lanes,
  output logic cmd_valid,
  output frame_class_type frame_class,
  output logic frame_done,
  output logic config_reset,
  output logic por_reset,
  output logic conv_busy
);

  initial begin
    if (CONV_LEN < 1 || CONV_LEN > 65535 || APP_LEN < 1 || APP_LEN > 65535 || POR_LEN < 1 || POR_LEN > 65535) begin
      $error("serial_frame_device: delay counts must lie in 1..65535");
    end
  end

  localparam logic [COUNT_W-1:0] CONV_END = COUNT_W'(CONV_LEN - 1);
  localparam logic [COUNT_W-1:0] APP_END = COUNT_W'(APP_LEN - 1);
  localparam logic [COUNT_W-1:0] POR_END = COUNT_W'(POR_LEN - 1);

  typedef struct packed {
    dev_state_type state;
    logic cs_meta;
    logic cs_now;
    logic cs_last;
    logic sclk_meta;
    logic sclk_now;
    logic sclk_last;
    logic din_meta;
    logic din_now;
    logic rst_meta;
    logic rst_now;
    logic rst_last;
    logic kind_app;
    logic frame;
    logic [WORD_BITS-1:0] shifter;
    logic [5:0] edges;
    logic out_bit;
    logic out_oe;
    logic ready;
    logic [COUNT_W-1:0] wait_count;
    logic [WORD_BITS-1:0] pending;
    cmd_op_type op;
    logic [8:0] addr;
    logic [15:0] data;
    logic [1:0] lanes;
    logic cmd_valid;
    frame_class_type fclass;
    logic frame_done;
    logic config_reset;
    logic por_reset;
  } dev_reg_type;

  localparam dev_reg_type RESET_VALUE = '{state: DEV_RESET, op: OPK_NONE, fclass: FRAME_SHORT, default: '0};

  dev_reg_type r;
  dev_reg_type next_r;

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  function automatic cmd_op_type decode_op(input logic [WORD_BITS-1:0] w);
    cmd_op_type op;
    op = OPK_NONE;
    case (w[OP_MSB:OP_LSB])
      OPC_CLEAR_HALF: op = OPK_CLEAR;
      OPC_READ_HALF: op = OPK_READ_HALF;
      OPC_READ_BYTE: op = OPK_READ_BYTE;
      OPC_SET_HALF: op = OPK_SET;
      OPC_WRITE: begin
        if (w[SUB_MSB:SUB_LSB] != 2'h3) begin
          op = OPK_WRITE;
        end
      end
      default: op = OPK_NONE;
    endcase
    return op;
  endfunction

  function automatic logic [1:0] decode_lanes(input logic [WORD_BITS-1:0] w, input cmd_op_type op);
    logic [1:0] lanes;
    lanes = LANES_HALF;
    if (op == OPK_READ_BYTE) begin
      lanes = LANES_LS;
    end else if (op == OPK_WRITE && w[SUB_MSB:SUB_LSB] == WR_SUB_MS) begin
      lanes = LANES_MS;
    end else if (op == OPK_WRITE && w[SUB_MSB:SUB_LSB] == WR_SUB_LS) begin
      lanes = LANES_LS;
    end else if (op == OPK_NONE) begin
      lanes = 2'h0;
    end
    return lanes;
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  cmd_op_type new_op;

  always_comb begin
    next_r = r;
    next_r.cmd_valid = 1'b0;
    next_r.frame_done = 1'b0;
    next_r.config_reset = 1'b0;
    next_r.por_reset = 1'b0;
    next_r.cs_meta = link.convert_start_select;
    next_r.cs_now = r.cs_meta;
    next_r.cs_last = r.cs_now;
    next_r.sclk_meta = link.sclk;
    next_r.sclk_now = r.sclk_meta;
    next_r.sclk_last = r.sclk_now;
    next_r.din_meta = link.serial_in_pin;
    next_r.din_now = r.din_meta;
    next_r.rst_meta = link.reset_pin_n;
    next_r.rst_now = r.rst_meta;
    next_r.rst_last = r.rst_now;
    cs_rise = r.cs_now & ~r.cs_last;
    cs_fall = ~r.cs_now & r.cs_last;
    sclk_rise = r.sclk_now & ~r.sclk_last;
    sclk_fall = ~r.sclk_now & r.sclk_last;
    new_op = decode_op(r.shifter);
    if (!r.rst_now) begin
      next_r.state = DEV_RESET;
      next_r.ready = 1'b0;
      next_r.out_oe = 1'b0;
      next_r.frame = 1'b0;
      next_r.wait_count = '0;
      next_r.pending = CMD_NO_OPERATION;
      if (r.rst_last) begin
        next_r.kind_app = reset_kind_select;
        next_r.config_reset = reset_kind_select;
        next_r.por_reset = ~reset_kind_select;
      end
    end else begin
      case (r.state)
        DEV_RESET: begin
          if (r.cs_now || r.sclk_now) begin
            next_r.wait_count = '0;
          end else if (r.wait_count == (r.kind_app ? APP_END : POR_END)) begin
            next_r.state = DEV_ACQ;
            next_r.ready = 1'b1;
            next_r.wait_count = '0;
          end else begin
            next_r.wait_count = r.wait_count + 1'b1;
          end
        end
        DEV_ACQ: begin
          if (cs_fall) begin
            next_r.frame = 1'b1;
            next_r.ready = 1'b0;
            next_r.edges = '0;
            next_r.shifter = output_word;
            next_r.out_bit = output_word[WORD_BITS-1];
            next_r.out_oe = 1'b1;
            next_r.pending = CMD_NO_OPERATION;
          end else if (cs_rise) begin
            next_r.state = DEV_CONV;
            next_r.frame = 1'b0;
            next_r.out_oe = 1'b0;
            next_r.ready = 1'b0;
            next_r.wait_count = '0;
            next_r.frame_done = 1'b1;
            if (r.frame && r.edges >= EDGE_OPTIMAL) begin
              next_r.pending = r.shifter;
              next_r.fclass = (r.edges == EDGE_OPTIMAL) ? FRAME_OPTIMAL : FRAME_LONG;
              next_r.op = new_op;
              next_r.addr = r.shifter[ADDR_MSB:ADDR_LSB];
              if (new_op != OPK_READ_BYTE) begin
                next_r.addr[0] = 1'b0;
              end
              next_r.data = r.shifter[DATA_MSB:DATA_LSB];
              next_r.lanes = decode_lanes(r.shifter, new_op);
              next_r.cmd_valid = 1'b1;
            end else begin
              next_r.pending = CMD_NO_OPERATION;
              next_r.fclass = FRAME_SHORT;
            end
          end else if (r.frame) begin
            if (sclk_rise) begin
              next_r.shifter = {r.shifter[WORD_BITS-2:0], r.din_now};
              if (r.edges != EDGE_SATURATE) begin
                next_r.edges = r.edges + 1'b1;
              end
            end
            if (sclk_fall) begin
              next_r.out_bit = r.shifter[WORD_BITS-1];
            end
          end
        end
        DEV_CONV: begin
          if (r.wait_count == CONV_END) begin
            next_r.state = DEV_ACQ;
            next_r.ready = 1'b1;
            next_r.wait_count = '0;
          end else begin
            next_r.wait_count = r.wait_count + 1'b1;
          end
        end
        default: begin
          next_r.state = DEV_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      r <= RESET_VALUE;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign link.serial_out_lane0 = r.out_bit;
  assign link.serial_out_lane0_oe = r.out_oe;
  assign link.ready_indicator = r.ready;
  assign cmd_op = r.op;
  assign cmd_addr = r.addr;
  assign cmd_data = r.data;
  assign cmd_lanes = r.lanes;
  assign cmd_valid = r.cmd_valid;
  assign frame_class = r.fclass;
  assign frame_done = r.frame_done;
  assign config_reset = r.config_reset;
  assign por_reset = r.por_reset;
  assign conv_busy = (r.state == DEV_CONV);

endmodule

//--- rtl/serial_frame_host.sv
module serial_frame_host
  import serial_frame_pkg::*;
#(
  parameter int CHAIN_LEN = 1,
  parameter int SCLK_HALF = SCLK_HALF_CYCLES,
  parameter int RST_LOW_LEN = RST_LOW_CYCLES,
  parameter int CONV_WAIT = CONV_MAX_CYCLES,
  parameter int POR_WAIT = RST_POR_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  serial_link_if.host link,
  input wire logic frame_start,
  input wire logic reset_start,
  input wire logic replicate,
  input wire logic [WORD_BITS*CHAIN_LEN-1:0] tx_word,
  output logic busy,
  output logic [WORD_BITS*CHAIN_LEN-1:0] rx_word,
  output logic rx_valid
);

  localparam int FRAME_W = WORD_BITS * CHAIN_LEN;

  initial begin
    if (CHAIN_LEN < 1 || FRAME_W > 65535 || SCLK_HALF < 4 || SCLK_HALF > 65535 || RST_LOW_LEN < 1
        || CONV_WAIT < 1 || CONV_WAIT > 65535 || POR_WAIT < 1 || POR_WAIT > 65535) begin
      $error("serial_frame_host: parameter out of range");
    end
  end

  localparam logic [COUNT_W-1:0] HALF_END = COUNT_W'(SCLK_HALF - 1);
  localparam logic [COUNT_W-1:0] RST_END = COUNT_W'(RST_LOW_LEN - 1);
  localparam logic [COUNT_W-1:0] CONV_END = COUNT_W'(CONV_WAIT - 1);
  localparam logic [COUNT_W-1:0] POR_END = COUNT_W'(POR_WAIT - 1);
  localparam logic [COUNT_W-1:0] BITS_END = COUNT_W'(FRAME_W);

  typedef struct packed {
    host_state_type state;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] bits;
    logic after_reset;
    logic [FRAME_W-1:0] tx;
    logic [FRAME_W-1:0] rx;
    logic [FRAME_W-1:0] rx_out;
    logic rx_valid;
    logic cs;
    logic sclk;
    logic mosi;
    logic rst_n;
    logic rdy_meta;
    logic rdy_now;
    logic rdy_last;
    logic miso_meta;
    logic miso_now;
  } host_reg_type;

  localparam host_reg_type RESET_VALUE = '{state: HOST_IDLE, cs: 1'b1, rst_n: 1'b1, default: '0};

  host_reg_type r;
  host_reg_type next_r;
  logic [FRAME_W-1:0] load_word;
  logic [COUNT_W-1:0] wait_end;

  always_comb begin
    next_r = r;
    next_r.rx_valid = 1'b0;
    next_r.rdy_meta = link.ready_indicator;
    next_r.rdy_now = r.rdy_meta;
    next_r.rdy_last = r.rdy_now;
    next_r.miso_meta = link.serial_out_lane0;
    next_r.miso_now = r.miso_meta;
    load_word = replicate ? {CHAIN_LEN{tx_word[WORD_BITS-1:0]}} : tx_word;
    wait_end = r.after_reset ? POR_END : CONV_END;
    case (r.state)
      HOST_IDLE: begin
        next_r.count = '0;
        if (reset_start) begin
          next_r.state = HOST_RESET;
          next_r.rst_n = 1'b0;
          next_r.cs = 1'b0;
          next_r.sclk = 1'b0;
        end else if (frame_start) begin
          next_r.state = HOST_FRAME;
          next_r.cs = 1'b0;
          next_r.sclk = 1'b0;
          next_r.tx = load_word;
          next_r.mosi = load_word[FRAME_W-1];
          next_r.bits = '0;
        end
      end
      HOST_RESET: begin
        if (r.count == RST_END) begin
          next_r.rst_n = 1'b1;
          next_r.count = '0;
          next_r.after_reset = 1'b1;
          next_r.state = HOST_WAIT;
        end else begin
          next_r.count = r.count + 1'b1;
        end
      end
      HOST_FRAME: begin
        if (r.count == HALF_END) begin
          next_r.count = '0;
          if (!r.sclk) begin
            if (r.bits == BITS_END) begin
              next_r.cs = 1'b1;
              next_r.rx_out = r.rx;
              next_r.rx_valid = 1'b1;
              next_r.after_reset = 1'b0;
              next_r.state = HOST_WAIT;
            end else begin
              next_r.sclk = 1'b1;
            end
          end else begin
            next_r.sclk = 1'b0;
            next_r.rx = {r.rx[FRAME_W-2:0], r.miso_now};
            next_r.tx = {r.tx[FRAME_W-2:0], 1'b0};
            next_r.mosi = r.tx[FRAME_W-2];
            next_r.bits = r.bits + 1'b1;
          end
        end else begin
          next_r.count = r.count + 1'b1;
        end
      end
      HOST_WAIT: begin
        if ((r.rdy_now && !r.rdy_last) || r.count == wait_end) begin
          next_r.count = '0;
          if (r.after_reset) begin
            next_r.cs = 1'b1;
            next_r.after_reset = 1'b0;
          end else begin
            next_r.state = HOST_IDLE;
          end
        end else begin
          next_r.count = r.count + 1'b1;
        end
      end
      default: begin
        next_r.state = HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      r <= RESET_VALUE;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign link.reset_pin_n = r.rst_n;
  assign link.convert_start_select = r.cs;
  assign link.sclk = r.sclk;
  assign link.serial_in_pin = r.mosi;
  assign busy = (r.state != HOST_IDLE);
  assign rx_word = r.rx_out;
  assign rx_valid = r.rx_valid;

endmodule

//--- rtl/serial_frame_pkg.sv
package serial_frame_pkg;

  // ------------------------------------------------------------
  // Frame geometry
  // ------------------------------------------------------------
  localparam int WORD_BITS = 32;
  localparam logic [5:0] EDGE_OPTIMAL = 6'h20;
  localparam logic [5:0] EDGE_SATURATE = 6'h3F;
  localparam logic [31:0] CMD_NO_OPERATION = 32'h00000000;

  // ------------------------------------------------------------
  // Command word fields
  // ------------------------------------------------------------
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 27;
  localparam int SUB_MSB = 26;
  localparam int SUB_LSB = 25;
  localparam int ADDR_MSB = 24;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int DATA_LSB = 0;
  localparam logic [4:0] OPC_CLEAR_HALF = 5'h18;
  localparam logic [4:0] OPC_READ_HALF = 5'h19;
  localparam logic [4:0] OPC_READ_BYTE = 5'h09;
  localparam logic [4:0] OPC_WRITE = 5'h1A;
  localparam logic [4:0] OPC_SET_HALF = 5'h1B;
  localparam logic [1:0] WR_SUB_BOTH = 2'h0;
  localparam logic [1:0] WR_SUB_MS = 2'h1;
  localparam logic [1:0] WR_SUB_LS = 2'h2;
  localparam logic [1:0] LANES_HALF = 2'h3;
  localparam logic [1:0] LANES_MS = 2'h2;
  localparam logic [1:0] LANES_LS = 2'h1;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_CONV_NS = 1000;
  localparam int T_CONV_MAX_NS = 1200;
  localparam int T_D_RST_APP_NS = 1000;
  localparam int T_D_RST_POR_NS = 20000;
  localparam int T_RST_LOW_NS = 100;
  localparam int T_SCLK_HALF_NS = 200;
  localparam int CONV_CYCLES = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYCLES = (T_CONV_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_APP_CYCLES = (T_D_RST_APP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_POR_CYCLES = (T_D_RST_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_LOW_CYCLES = (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYCLES = (T_SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COUNT_W = 16;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_RESET = 3'b001,
    DEV_ACQ = 3'b010,
    DEV_CONV = 3'b100
  } dev_state_type;

  typedef enum logic [3:0] {
    HOST_IDLE = 4'b0001,
    HOST_RESET = 4'b0010,
    HOST_FRAME = 4'b0100,
    HOST_WAIT = 4'b1000
  } host_state_type;

  typedef enum logic [2:0] {
    OPK_NONE = 3'h0,
    OPK_CLEAR = 3'h1,
    OPK_READ_HALF = 3'h2,
    OPK_READ_BYTE = 3'h3,
    OPK_WRITE = 3'h4,
    OPK_SET = 3'h5
  } cmd_op_type;

  typedef enum logic [1:0] {
    FRAME_SHORT = 2'h0,
    FRAME_OPTIMAL = 2'h1,
    FRAME_LONG = 2'h2
  } frame_class_type;

endpackage

//--- rtl/serial_link_if.sv
interface serial_link_if;
  logic reset_pin_n;
  logic convert_start_select;
  logic sclk;
  logic serial_in_pin;
  logic serial_out_lane0;
  logic serial_out_lane0_oe;
  logic ready_indicator;

  modport device (
    input reset_pin_n,
    input convert_start_select,
    input sclk,
    input serial_in_pin,
    output serial_out_lane0,
    output serial_out_lane0_oe,
    output ready_indicator
  );

  modport host (
    output reset_pin_n,
    output convert_start_select,
    output sclk,
    output serial_in_pin,
    input serial_out_lane0,
    input serial_out_lane0_oe,
    input ready_indicator
  );
endinterface

//--- verification/serial_frame_assertions.sv
module serial_frame_assertions #(
  parameter int CONV_LEN = 5
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reset_pin_n,
  input wire logic convert_start_select,
  input wire logic sclk,
  input wire logic serial_in_pin,
  input wire logic serial_out_lane0,
  input wire logic serial_out_lane0_oe,
  input wire logic ready_indicator
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV_LO = CONV_LEN + 2;
  localparam int CONV_HI = CONV_LEN + 8;
  logic cs_d;
  logic sclk_d;
  logic [7:0] edge_cnt;

  // ------------------------------------------------------------
  // Capture edges counted per frame
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    cs_d <= convert_start_select;
    sclk_d <= sclk;
    if (!resetn || (cs_d && !convert_start_select)) begin
      edge_cnt <= 8'h00;
    end else if (!sclk_d && sclk && !convert_start_select) begin
      edge_cnt <= edge_cnt + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Link checks
  // ------------------------------------------------------------
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  a_ready_frame_low: assert property (ready_indicator && $fell(convert_start_select) && reset_pin_n |->
    ##[1:5] !ready_indicator) else $error("ready stayed high after frame start");
  a_oe_frame_on: assert property ((ready_indicator && $fell(convert_start_select) && reset_pin_n)
    ##1 reset_pin_n [*4] |-> serial_out_lane0_oe) else $error("lane not driven in frame");
  a_oe_after_rise: assert property ($rose(convert_start_select) |-> ##6 !serial_out_lane0_oe)
    else $error("lane still driven after frame end");
  a_lane_stable_high: assert property (sclk && $past(sclk) && serial_out_lane0_oe |->
    $stable(serial_out_lane0)) else $error("lane changed while clock high");
  a_ready_conv_low: assert property ($rose(convert_start_select) && reset_pin_n |->
    ##5 !ready_indicator ##1 !ready_indicator) else $error("conversion ended too early");
  a_conv_ends: assert property ($rose(convert_start_select) && reset_pin_n |->
    ##[CONV_LO:CONV_HI] ready_indicator) else $error("ready did not return after conversion");
  a_frame_edge_count: assert property ($rose(convert_start_select) |->
    edge_cnt == 8'h20 || edge_cnt == 8'h00) else $error("frame edge count wrong");
  a_reset_release: assert property ($rose(reset_pin_n) |-> !convert_start_select && !sclk)
    else $error("reset released with select or clock high");
  a_sclk_idle: assert property (convert_start_select |-> !sclk)
    else $error("serial clock outside frame");
  a_reset_quiet: assert property (!reset_pin_n [*5] |-> !ready_indicator && !serial_out_lane0_oe)
    else $error("outputs active during reset");
  a_reset_width: assert property ($fell(reset_pin_n) |-> !reset_pin_n [*6])
    else $error("reset pulse too short");
  a_sclk_half_period: assert property ($rose(sclk) |-> sclk [*4])
    else $error("serial clock high phase too short");

  c_optimal: cover property ($rose(convert_start_select) && edge_cnt == 8'h20);
  c_reset: cover property ($fell(reset_pin_n));
  c_conv_done: cover property ($rose(ready_indicator));
  c_data_one: cover property (!convert_start_select && sclk && serial_in_pin);
endmodule

//--- verification/tb_top.sv
module tb_top
  import serial_frame_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic kind = 1'b0;
  logic frame_start = 1'b0;
  logic reset_start = 1'b0;
  logic replicate = 1'b0;
  logic [31:0] tx_word = 32'h00000000;
  logic [31:0] out_word = 32'hC3A50F1E;
  logic [31:0] rx_word;
  logic busy, rx_valid, cmd_valid, frame_done, config_reset, por_reset, conv_busy;
  logic cmd_valid2, frame_done2, got_cmd, got_cfg, got_por, got_rx, got_done;
  cmd_op_type cmd_op, cmd_op2;
  logic [8:0] cmd_addr, cmd_addr2;
  logic [15:0] cmd_data;
  logic [1:0] cmd_lanes;
  frame_class_type frame_class, frame_class2;
  logic [63:0] got;
  int n_fail = 0;
  int n_compared = 0;
  int n_cmd2, n_done2;
  logic [31:0] cmds [10] = '{{OPC_CLEAR_HALF, 2'h3, 9'h005, 16'hF00F}, {OPC_READ_HALF, 2'h0, 9'h103, 16'h0000},
    {OPC_READ_BYTE, 2'h1, 9'h007, 16'h0000}, {OPC_WRITE, WR_SUB_BOTH, 9'h011, 16'h1234},
    {OPC_WRITE, WR_SUB_MS, 9'h014, 16'hABCD}, {OPC_WRITE, WR_SUB_LS, 9'h1FF, 16'h5AA5},
    {OPC_SET_HALF, 2'h2, 9'h0C9, 16'h8001}, {5'h1F, 2'h0, 9'h004, 16'h1111},
    {OPC_WRITE, 2'h3, 9'h004, 16'h2222}, CMD_NO_OPERATION};
  cmd_op_type exp_op [10] = '{OPK_CLEAR, OPK_READ_HALF, OPK_READ_BYTE, OPK_WRITE, OPK_WRITE, OPK_WRITE,
    OPK_SET, OPK_NONE, OPK_NONE, OPK_NONE};
  logic [8:0] exp_addr [10] = '{9'h004, 9'h102, 9'h007, 9'h010, 9'h014, 9'h1FE, 9'h0C8, 9'h000, 9'h000, 9'h000};
  logic [1:0] exp_lanes [10] = '{LANES_HALF, LANES_HALF, LANES_LS, LANES_HALF, LANES_MS, LANES_LS, LANES_HALF,
    2'h0, 2'h0, 2'h0};

  serial_link_if link();
  serial_link_if link2();

  // ------------------------------------------------------------
  // Both ends joined, plus a device on a bench-driven link
  // ------------------------------------------------------------
  serial_frame_host #(.CHAIN_LEN(1), .RST_LOW_LEN(6), .CONV_WAIT(13), .POR_WAIT(40)) u_serial_frame_host (
    .mclk(mclk), .resetn(resetn), .clk_en(clk_en), .link(link.host), .frame_start(frame_start),
    .reset_start(reset_start), .replicate(replicate), .tx_word(tx_word), .busy(busy), .rx_word(rx_word),
    .rx_valid(rx_valid));
  serial_frame_device #(.CONV_LEN(5), .POR_LEN(30)) u_serial_frame_device (
    .mclk(mclk), .resetn(resetn), .clk_en(clk_en), .link(link.device), .output_word(out_word),
    .reset_kind_select(kind), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_lanes(cmd_lanes),
    .cmd_valid(cmd_valid), .frame_class(frame_class), .frame_done(frame_done), .config_reset(config_reset),
    .por_reset(por_reset), .conv_busy(conv_busy));
  serial_frame_device #(.CONV_LEN(12), .POR_LEN(30)) u_serial_frame_device2 (
    .mclk(mclk), .resetn(resetn), .clk_en(clk_en), .link(link2.device), .output_word(out_word),
    .reset_kind_select(kind), .cmd_op(cmd_op2), .cmd_addr(cmd_addr2), .cmd_data(), .cmd_lanes(),
    .cmd_valid(cmd_valid2), .frame_class(frame_class2), .frame_done(frame_done2), .config_reset(),
    .por_reset(), .conv_busy());
  serial_frame_assertions #(.CONV_LEN(5)) u_serial_frame_assertions (
    .mclk(mclk), .resetn(resetn), .reset_pin_n(link.reset_pin_n), .convert_start_select(link.convert_start_select),
    .sclk(link.sclk), .serial_in_pin(link.serial_in_pin), .serial_out_lane0(link.serial_out_lane0),
    .serial_out_lane0_oe(link.serial_out_lane0_oe), .ready_indicator(link.ready_indicator));

  initial begin
    forever #25 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task cmp(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task results;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic host_op(input logic [31:0] w, input logic rst);
    int k;
    got_cmd = 1'b0;
    got_cfg = 1'b0;
    got_por = 1'b0;
    got_rx = 1'b0;
    got_done = 1'b0;
    tx_word = w;
    frame_start = !rst;
    reset_start = rst;
    @(negedge mclk);
    frame_start = 1'b0;
    reset_start = 1'b0;
    for (k = 0; k < 1000 && (k < 2 || busy !== 1'b0); k++) begin
      @(negedge mclk);
      got_cmd |= cmd_valid === 1'b1;
      got_cfg |= config_reset === 1'b1;
      got_por |= por_reset === 1'b1;
      got_rx |= rx_valid === 1'b1;
      got_done |= frame_done === 1'b1 && conv_busy === 1'b1;
    end
    if (k == 1000) begin
      n_fail++;
      results();
    end
  endtask

  // Bit-banged frame on the second link, mode 0, optional select glitch in conversion
  task automatic bb(input logic [63:0] bits, input int n, input logic glitch);
    int k;
    got = 64'h0;
    n_cmd2 = 0;
    n_done2 = 0;
    link2.convert_start_select = 1'b0;
    repeat (6) @(negedge mclk);
    for (k = n - 1; k >= 0; k--) begin
      link2.serial_in_pin = bits[k];
      repeat (4) @(negedge mclk);
      link2.sclk = 1'b1;
      got = {got[62:0], link2.serial_out_lane0};
      repeat (4) @(negedge mclk);
      link2.sclk = 1'b0;
    end
    repeat (4) @(negedge mclk);
    link2.convert_start_select = 1'b1;
    for (k = 0; k < 80 && (k < 12 || link2.ready_indicator !== 1'b1); k++) begin
      @(negedge mclk);
      if (k == 5 && glitch) link2.convert_start_select = 1'b0;
      if (k == 7) link2.convert_start_select = 1'b1;
      n_cmd2 += cmd_valid2 === 1'b1;
      n_done2 += frame_done2 === 1'b1;
    end
    if (k == 80) begin
      n_fail++;
      results();
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    link2.reset_pin_n = 1'b1;
    link2.convert_start_select = 1'b0;
    link2.sclk = 1'b0;
    link2.serial_in_pin = 1'b0;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    for (int i = 0; i < 2; i++) begin
      kind = i[0];
      host_op(32'h00000000, 1'b1);
      cmp("config_reset", got_cfg, kind);
      cmp("por_reset", got_por, !kind);
      cmp("ready", link.ready_indicator, 1);
      cmp("frame_class", frame_class, FRAME_SHORT);
      cmp("cmd_valid", got_cmd, 0);
    end
    bb(64'h0, 0, 1'b0);
    for (int i = 0; i < 10; i++) begin
      replicate = i[0];
      host_op(cmds[i], 1'b0);
      cmp("rx_word", rx_word, out_word);
      cmp("rx_valid", got_rx, 1);
      cmp("frame_done", got_done, 1);
      cmp("cmd_valid", got_cmd, 1);
      cmp("frame_class", frame_class, FRAME_OPTIMAL);
      cmp("cmd_op", cmd_op, exp_op[i]);
      if (exp_op[i] != OPK_NONE) begin
        cmp("cmd_addr", cmd_addr, exp_addr[i]);
        cmp("cmd_data", cmd_data, cmds[i][15:0]);
        cmp("cmd_lanes", cmd_lanes, exp_lanes[i]);
      end
      out_word = ~out_word;
    end
    bb({24'h000000, 8'hA5, OPC_SET_HALF, 2'h0, 9'h0F1, 16'h1234}, 40, 1'b1);
    cmp("long_bits", got[39:8], out_word);
    cmp("long_class", frame_class2, FRAME_LONG);
    cmp("long_op", cmd_op2, OPK_SET);
    cmp("long_addr", cmd_addr2, 9'h0F0);
    cmp("conv_frames", n_done2, 1);
    bb(64'hFF, 8, 1'b0);
    cmp("short_bits", got[7:0], out_word[31:24]);
    cmp("short_cmd", n_cmd2, 0);
    cmp("short_class", frame_class2, FRAME_SHORT);
    repeat (20) @(negedge mclk);
    cmp("idle_ready", link2.ready_indicator, 1);
    cmp("idle_oe", link2.serial_out_lane0_oe, 0);
    clk_en = 1'b0;
    frame_start = 1'b1;
    @(negedge mclk);
    frame_start = 1'b0;
    clk_en = 1'b1;
    @(negedge mclk);
    cmp("frozen_busy", busy, 0);
    results();
  end
endmodule
